//--- hdl/cable_diag_defs.svh
/*
  Offsets, field positions, reset values and bus figures for the cable
  diagnostic amplitude result registers.
  Assumes a 32-bit Wishbone word per register index, byte address = 4 * index.
*/
`ifndef CABLE_DIAG_DEFS_SVH
`define CABLE_DIAG_DEFS_SVH

// ********************************************************************
// Register indices (byte address is four times the index)
// ********************************************************************
`define IDX_DIAG_CONTROL_REG   16'h001E
`define IDX_TX_PEAK_LOC_3_4    16'h0181
`define IDX_RX1_TX5_PEAK_LOC   16'h0182
`define IDX_RX_PEAK_LOC_2_3    16'h0183
`define IDX_TX_PEAK_AMP_3_4    16'h0186
`define IDX_RX1_TX5_PEAK_AMP   16'h0187
`define IDX_RX_PEAK_AMP_2_3    16'h0188

// ********************************************************************
// Field positions and reset values
// ********************************************************************
`define DIAG_DONE_BIT          1
`define DIAG_BUSY_BIT          0
`define AMP_HI_LSB             8
`define AMP_LO_LSB             0
`define AMP_W                  7
`define LOC_W                  8
`define AMP_RESET              7'h00
`define LOC_RESET              8'h00
`define RDATA_RESET            32'h0000_0000
`define UNMAPPED_RDATA         32'h0000_0000

// ********************************************************************
// Bus figures
// ********************************************************************
`define WB_DATA_W              32
`define WB_SEL_W               4
`define MIN_ADDR_W             11

`endif

//--- hdl/cable_diag_pkg.sv
/*
  Types for the cable diagnostic amplitude result block.
  Assumes cable_diag_defs.svh is on the include path.
*/
`include "cable_diag_defs.svh"

package cable_diag_pkg;

  // ********************************************************************
  // Result carriers
  // ********************************************************************
  typedef struct packed {
    logic [`AMP_W-1:0] tx4;
    logic [`AMP_W-1:0] tx3;
    logic [`AMP_W-1:0] rx1;
    logic [`AMP_W-1:0] tx5;
    logic [`AMP_W-1:0] rx3;
    logic [`AMP_W-1:0] rx2;
  } amp_set_t;

  typedef struct packed {
    logic [`LOC_W-1:0] tx4;
    logic [`LOC_W-1:0] tx3;
    logic [`LOC_W-1:0] rx1;
    logic [`LOC_W-1:0] tx5;
    logic [`LOC_W-1:0] rx3;
    logic [`LOC_W-1:0] rx2;
  } loc_set_t;

  // ********************************************************************
  // Run tracking and module state
  // ********************************************************************
  typedef enum logic [1:0] {
    RUN_IDLE = 2'b00,
    RUN_BUSY = 2'b01,
    RUN_DONE = 2'b10
  } run_state_t;

  typedef struct packed {
    run_state_t             run;
    amp_set_t               amp;
    loc_set_t               loc;
    logic [`WB_DATA_W-1:0]  rdata;
  } diag_state_t;

  typedef struct packed {
    logic ack;
    logic err;
  } wb_state_t;

endpackage

//--- hdl/wb_classic_slave.sv
/*
  Classic Wishbone slave handshake: one wait state, ack or err for one cycle.
  Assumes the parent reports whether the decoded index is mapped.
*/
`timescale 1ns/1ps
`default_nettype none

module wb_classic_slave #(
  parameter int ADDR_W = 12
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              cyc_i,
  input  wire logic              stb_i,
  input  wire logic [ADDR_W-1:0] adr_i,
  input  wire logic              hit_i,
  output logic [15:0]            idx_o,
  output logic                   take_o,
  output logic                   ack_o,
  output logic                   err_o
);

  cable_diag_pkg::wb_state_t st;
  cable_diag_pkg::wb_state_t next_st;

  // ********************************************************************
  // Decode and answer
  // ********************************************************************
  // Blocking a new take while an answer stands keeps one answer per request
  assign take_o = cyc_i & stb_i & ~st.ack & ~st.err;
  assign idx_o  = 16'(adr_i[ADDR_W-1:2]);
  assign ack_o  = st.ack;
  assign err_o  = st.err;

  always_comb begin
    next_st.ack = take_o & hit_i;
    next_st.err = take_o & ~hit_i;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule

`default_nettype wire

//--- hdl/cable_diag_amplitude_results.sv
/*
  Cable diagnostic amplitude (and matching location) result registers,
  read by software over classic Wishbone, loaded by the reflectometry engine.
  Assumes the engine pulses diag_start_i when a run begins and diag_done_i for
  one cycle with amp_i and loc_i valid when the run completes.
*/
// Operation
// [R1] Results mean something only after software reads the done flag, bit 1 of the control word at 0x1E, as one.
// [R2] Bits 15 and 7 of each amplitude register ignore writes and always read zero.
// [R3] Index 0x186 returns transmit peak 4 amplitude in 14:8 and peak 3 in 6:0, paired with location 0x181.
// [R4] Index 0x187 returns receive peak 1 amplitude in 14:8 and transmit peak 5 in 6:0, paired with 0x182.
// [R5] Index 0x188 returns receive peak 3 amplitude in 14:8 and receive peak 2 in 6:0, paired with 0x183.
// [R6] Every 7-bit amplitude field is read only and resets to zero.
// [R7] Location registers hold one 8-bit location per peak, byte-matched to the amplitude fields.
// [R8] All fields load when a run completes and stay stable until the next run or a reset.
`timescale 1ns/1ps
`default_nettype none

`include "cable_diag_defs.svh"

module cable_diag_amplitude_results #(
  parameter int ADDR_W = 12
) (
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  input  wire logic                      wb_cyc_i,
  input  wire logic                      wb_stb_i,
  input  wire logic                      wb_we_i,
  input  wire logic [ADDR_W-1:0]         wb_adr_i,
  input  wire logic [`WB_SEL_W-1:0]      wb_sel_i,
  input  wire logic [`WB_DATA_W-1:0]     wb_dat_i,
  output logic      [`WB_DATA_W-1:0]     wb_dat_o,
  output logic                           wb_ack_o,
  output logic                           wb_err_o,
  input  wire logic                      diag_start_i,
  input  wire logic                      diag_done_i,
  input  wire cable_diag_pkg::amp_set_t  amp_i,
  input  wire cable_diag_pkg::loc_set_t  loc_i,
  output logic                           diag_busy_o,
  output logic                           diag_done_o
);

  // ********************************************************************
  // Elaboration checks
  // ********************************************************************
  // The highest index 0x188 needs nine index bits above the byte lanes
  if (ADDR_W < `MIN_ADDR_W) begin : g_addr_check
    $error("ADDR_W too small to reach the result registers");
  end

  // The index is carried in 16 bits, so a wider byte address would alias
  if (ADDR_W > 18) begin : g_addr_wide_check
    $error("ADDR_W too wide for the 16-bit register index");
  end

  // Both amplitude fields must stay clear of reserved bits 15 and 7
  if ((`AMP_HI_LSB + `AMP_W > 15) || (`AMP_LO_LSB + `AMP_W > 7)) begin : g_amp_field_check
    $error("Amplitude field would reach a reserved bit");
  end

  // Both location bytes share one 16-bit word without overlapping
  if (`LOC_W > `AMP_HI_LSB) begin : g_loc_field_check
    $error("Location fields would overlap");
  end

  // Every register word is 16 bits wide, so the bus must carry at least that
  if (`WB_DATA_W < 16) begin : g_bus_width_check
    $error("Bus data width below the 16-bit register width");
  end

  // ********************************************************************
  // Helpers
  // ********************************************************************
  // Reserved bits 15 and 7 are forced to zero here, whatever is stored
  function automatic logic [`WB_DATA_W-1:0] pack_amp(
    input logic [`AMP_W-1:0] hi,
    input logic [`AMP_W-1:0] lo
  );
    logic [`WB_DATA_W-1:0] w;
    w = '0;
    w[`AMP_HI_LSB +: `AMP_W] = hi;  // R2
    w[`AMP_LO_LSB +: `AMP_W] = lo;  // R2
    return w;
  endfunction

  function automatic logic [`WB_DATA_W-1:0] pack_loc(
    input logic [`LOC_W-1:0] hi,
    input logic [`LOC_W-1:0] lo
  );
    logic [`WB_DATA_W-1:0] w;
    w = '0;
    w[`AMP_HI_LSB +: `LOC_W] = hi;
    w[`AMP_LO_LSB +: `LOC_W] = lo;
    return w;
  endfunction

  function automatic logic is_mapped(input logic [15:0] idx);
    case (idx)
      `IDX_DIAG_CONTROL_REG,
      `IDX_TX_PEAK_LOC_3_4,
      `IDX_RX1_TX5_PEAK_LOC,
      `IDX_RX_PEAK_LOC_2_3,
      `IDX_TX_PEAK_AMP_3_4,
      `IDX_RX1_TX5_PEAK_AMP,
      `IDX_RX_PEAK_AMP_2_3: is_mapped = 1'b1;
      default:              is_mapped = 1'b0;
    endcase
  endfunction

  // ********************************************************************
  // Bus handshake
  // ********************************************************************
  logic [15:0] idx;
  logic        take;
  logic        hit;

  // Unmapped indices answer with err, so a stray address is visible to software
  assign hit = is_mapped(idx);

  wb_classic_slave #(
    .ADDR_W (ADDR_W)
  ) u_slave (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .cyc_i  (wb_cyc_i),
    .stb_i  (wb_stb_i),
    .adr_i  (wb_adr_i),
    .hit_i  (hit),
    .idx_o  (idx),
    .take_o (take),
    .ack_o  (wb_ack_o),
    .err_o  (wb_err_o)
  );

  // ********************************************************************
  // State
  // ********************************************************************
  cable_diag_pkg::diag_state_t st;
  cable_diag_pkg::diag_state_t next_st;
  logic [`WB_DATA_W-1:0]       read_word;
  logic [`WB_DATA_W-1:0]       ctrl_word;

  always_comb begin
    ctrl_word = '0;
    ctrl_word[`DIAG_DONE_BIT] = (st.run == cable_diag_pkg::RUN_DONE);  // R1
    ctrl_word[`DIAG_BUSY_BIT] = (st.run == cable_diag_pkg::RUN_BUSY);
  end

  // ********************************************************************
  // Read decode
  // ********************************************************************
  // Writes have no path into any field: every register here is read only
  always_comb begin
    case (idx)
      `IDX_DIAG_CONTROL_REG: read_word = ctrl_word;
      `IDX_TX_PEAK_LOC_3_4:  read_word = pack_loc(st.loc.tx4, st.loc.tx3);  // R7
      `IDX_RX1_TX5_PEAK_LOC: read_word = pack_loc(st.loc.rx1, st.loc.tx5);  // R7
      `IDX_RX_PEAK_LOC_2_3:  read_word = pack_loc(st.loc.rx3, st.loc.rx2);  // R7
      `IDX_TX_PEAK_AMP_3_4:  read_word = pack_amp(st.amp.tx4, st.amp.tx3);  // R3
      `IDX_RX1_TX5_PEAK_AMP: read_word = pack_amp(st.amp.rx1, st.amp.tx5);  // R4
      `IDX_RX_PEAK_AMP_2_3:  read_word = pack_amp(st.amp.rx3, st.amp.rx2);  // R5
      default:               read_word = `UNMAPPED_RDATA;
    endcase
  end

  // ********************************************************************
  // Run tracking and result capture
  // ********************************************************************
  always_comb begin
    next_st = st;
    case (st.run)
      cable_diag_pkg::RUN_IDLE,
      cable_diag_pkg::RUN_DONE: begin
        // Completion wins if it lands with a start in the same cycle
        if (diag_done_i) begin
          next_st.run = cable_diag_pkg::RUN_DONE;  // R1
        end else if (diag_start_i) begin
          next_st.run = cable_diag_pkg::RUN_BUSY;  // R1
        end
      end
      cable_diag_pkg::RUN_BUSY: begin
        if (diag_done_i) begin
          next_st.run = cable_diag_pkg::RUN_DONE;  // R1
        end
      end
      default: begin
        next_st.run = cable_diag_pkg::RUN_IDLE;
      end
    endcase
    // Results change only on completion, so a read never sees a half-load
    if (diag_done_i) begin
      next_st.amp = amp_i;  // R8
      next_st.loc = loc_i;  // R8
    end
    // Read data is captured in the same cycle the request is taken
    if (take) begin
      next_st.rdata = wb_we_i ? `RDATA_RESET : read_word;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      // Clearing every field means reads before the first run return zero
      st.run   <= cable_diag_pkg::RUN_IDLE;
      st.amp   <= {6{`AMP_RESET}};  // R6
      st.loc   <= {6{`LOC_RESET}};
      st.rdata <= `RDATA_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ********************************************************************
  // Outputs
  // ********************************************************************
  // Flags decode the run state itself, so they never disagree with the status word
  assign wb_dat_o    = st.rdata;
  assign diag_busy_o = (st.run == cable_diag_pkg::RUN_BUSY);
  assign diag_done_o = (st.run == cable_diag_pkg::RUN_DONE);

endmodule

`default_nettype wire

//--- tb/cable_diag_amplitude_results_asserts.sv
/* Checker on the amplitude result block's ports.
   Assumes the bench binds it to the top module. */
`timescale 1ns/1ps
`default_nettype none
`include "cable_diag_defs.svh"
module cable_diag_asserts #(
  parameter int ADDR_W = 12
) (
  input wire logic                     clk_i,
  input wire logic                     rst_i,
  input wire logic                     wb_cyc_i,
  input wire logic                     wb_stb_i,
  input wire logic                     wb_we_i,
  input wire logic [ADDR_W-1:0]        wb_adr_i,
  input wire logic [31:0]              wb_dat_o,
  input wire logic                     wb_ack_o,
  input wire logic                     wb_err_o,
  input wire logic                     diag_start_i,
  input wire logic                     diag_done_i,
  input wire cable_diag_pkg::amp_set_t amp_i,
  input wire cable_diag_pkg::loc_set_t loc_i,
  input wire logic                     diag_busy_o,
  input wire logic                     diag_done_o
);
  cable_diag_pkg::amp_set_t amp_q;
  cable_diag_pkg::loc_set_t loc_q;
  logic                     tk;
  logic [15:0]              idx;
  logic                     amp_idx;
  // Shadow of the last run; engine traffic on the taking edge is left out as a race
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      amp_q <= '0;
      loc_q <= '0;
    end else if (diag_done_i) begin
      amp_q <= amp_i;
      loc_q <= loc_i;
    end
  end
  assign tk  = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o && !diag_done_i && !diag_start_i;
  assign idx = 16'(wb_adr_i[ADDR_W-1:2]);
  assign amp_idx = idx == `IDX_TX_PEAK_AMP_3_4 || idx == `IDX_RX1_TX5_PEAK_AMP ||
    idx == `IDX_RX_PEAK_AMP_2_3;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence rd_s(int i);
    tk && !wb_we_i && idx == 16'(i);
  endsequence
  status_read_a: assert property (rd_s(`IDX_DIAG_CONTROL_REG) |=>
    wb_dat_o == {30'h0000_0000, $past(diag_done_o), $past(diag_busy_o)}) else $error("status");
  rsv_bits_zero_a: assert property (tk && amp_idx |=> wb_ack_o && !wb_dat_o[15] && !wb_dat_o[7])
    else $error("reserved bit set");
  tx_amp_word_a: assert property (rd_s(`IDX_TX_PEAK_AMP_3_4) |=> wb_ack_o &&
    wb_dat_o == {17'h0_0000, amp_q.tx4, 1'b0, amp_q.tx3}) else $error("tx amp word");
  mixed_amp_word_a: assert property (rd_s(`IDX_RX1_TX5_PEAK_AMP) |=> wb_ack_o &&
    wb_dat_o == {17'h0_0000, amp_q.rx1, 1'b0, amp_q.tx5}) else $error("mixed amp word");
  rx_amp_word_a: assert property (rd_s(`IDX_RX_PEAK_AMP_2_3) |=> wb_ack_o &&
    wb_dat_o == {17'h0_0000, amp_q.rx3, 1'b0, amp_q.rx2}) else $error("rx amp word");
  write_ignored_a: assert property (tk && wb_we_i && amp_idx |=> wb_ack_o && wb_dat_o == '0)
    else $error("write answer");
  tx_loc_word_a: assert property (rd_s(`IDX_TX_PEAK_LOC_3_4) |=>
    wb_dat_o == {16'h0000, loc_q.tx4, loc_q.tx3}) else $error("tx loc word");
  run_done_a: assert property (diag_done_i |=> diag_done_o && !diag_busy_o)
    else $error("done not set");
  done_holds_a: assert property (diag_done_o && !diag_start_i |=> diag_done_o)
    else $error("done dropped");
endmodule
`default_nettype wire

//--- tb/cable_diag_amplitude_results_tb.sv
/* Self-checking bench for the amplitude result block.
   Drives Wishbone and the engine link itself; no partner model. */
`timescale 1ns/1ps
`default_nettype none
`include "cable_diag_defs.svh"
module cable_diag_amplitude_results_tb;
  typedef struct packed {
    logic [15:0] idx;
    logic [31:0] exp;
    logic        err;
  } row_t;
  logic                     clk_i = 1'b0;
  logic                     rst_i = 1'b1;
  logic                     cyc = 1'b0, stb = 1'b0, we = 1'b0, start = 1'b0, done = 1'b0;
  logic [11:0]              adr = 12'h000;
  logic [31:0]              wdat = 32'h0000_0000;
  logic [31:0]              rdat, d;
  logic                     ack, err, busy, fin, e;
  cable_diag_pkg::amp_set_t amp = '0;
  cable_diag_pkg::loc_set_t loc = '0;
  int                       n_fail = 0, n_compared = 0, cycles = 0;
  row_t rows [8] = '{'{16'h001E, 32'h0000_0002, 1'b0}, '{16'h0181, 32'h0000_A11B, 1'b0},
    '{16'h0182, 32'h0000_C23D, 1'b0}, '{16'h0183, 32'h0000_E45F, 1'b0},
    '{16'h0186, 32'h0000_552A, 1'b0}, '{16'h0187, 32'h0000_7F01, 1'b0},
    '{16'h0188, 32'h0000_403F, 1'b0}, '{16'h0185, 32'h0000_0000, 1'b1}};
  cable_diag_amplitude_results dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err), .diag_start_i(start),
    .diag_done_i(done), .amp_i(amp), .loc_i(loc), .diag_busy_o(busy), .diag_done_o(fin));
  always #2 clk_i = ~clk_i;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    if (n_fail == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ****************************************
  // Bus cycle: answer and read data are taken at the rising edge that shows them
  // ****************************************
  task automatic wb(input logic w, input logic [15:0] i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {i[9:0], 2'b00};
    @(posedge clk_i);
    while (ack !== 1'b1 && err !== 1'b1) @(posedge clk_i);
    d = rdat;
    e = err;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic engine(input logic s, input logic f);
    start <= s;
    done <= f;
    @(posedge clk_i);
    start <= 1'b0;
    done <= 1'b0;
    amp <= ~amp;
    loc <= ~loc;
    @(posedge clk_i);
  endtask
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 2000) begin
      n_fail++;
      summarize();
    end
  end
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(1'b0, `IDX_TX_PEAK_AMP_3_4);
    chk(d, 32'h0000_0000);
    engine(1'b1, 1'b0);
    chk({30'h0000_0000, fin, busy}, 32'h0000_0001);
    wb(1'b0, `IDX_DIAG_CONTROL_REG);
    chk(d, 32'h0000_0001);
    amp <= {7'h55, 7'h2A, 7'h7F, 7'h01, 7'h40, 7'h3F};
    loc <= 48'hA11B_C23D_E45F;
    engine(1'b0, 1'b1);
    chk({30'h0000_0000, fin, busy}, 32'h0000_0002);
    foreach (rows[k]) begin
      wb(1'b0, rows[k].idx);
      chk(d, rows[k].exp);
      chk({31'h0000_0000, e}, {31'h0000_0000, rows[k].err});
    end
    wdat <= 32'hFFFF_FFFF;
    wb(1'b1, `IDX_TX_PEAK_AMP_3_4);
    chk(d, 32'h0000_0000);
    wb(1'b0, `IDX_TX_PEAK_AMP_3_4);
    chk(d, 32'h0000_552A);
    amp <= '1;
    engine(1'b0, 1'b1);
    engine(1'b1, 1'b0);
    wb(1'b0, `IDX_RX1_TX5_PEAK_AMP);
    chk(d, 32'h0000_7F7F);
    wb(1'b0, `IDX_DIAG_CONTROL_REG);
    chk(d, 32'h0000_0001);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(1'b0, `IDX_RX_PEAK_AMP_2_3);
    chk(d, 32'h0000_0000);
    wb(1'b0, `IDX_DIAG_CONTROL_REG);
    chk(d, 32'h0000_0000);
    engine(1'b1, 1'b1);
    chk({30'h0000_0000, fin, busy}, 32'h0000_0002);
    summarize();
  end
endmodule
bind cable_diag_amplitude_results cable_diag_asserts #(.ADDR_W(ADDR_W)) chk_u (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
  .diag_start_i(diag_start_i), .diag_done_i(diag_done_i), .amp_i(amp_i), .loc_i(loc_i),
  .diag_busy_o(diag_busy_o), .diag_done_o(diag_done_o));
`default_nettype wire
